// [rtl/adc_result_and_trigger_regs.sv]
// Converter result pair, trigger control and pin input disable registers.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module adc_result_and_trigger_regs
  import adc_regs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic left_adjust,
  input wire logic [9:0] conversion_result,
  input wire logic [6:0] event_flags,
  input wire logic [7:0] pin_levels,
  output logic [7:0] port_input,
  output logic [7:0] pin_buffer_enable,
  output logic conversion_start,
  output logic converter_busy,
  output logic irq
);

  //////////////////////////////////////////////////////////////////////////
  // Bus decode.

  bus_req_s req;
  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  logic wr_ctrl;
  logic wr_trig;
  logic wr_didr;
  logic wr_mask;
  logic rd_low;
  logic rd_high;
  logic rd_stat;
  assign wr_ctrl = req.wr && req.addr == control_a_addr;
  assign wr_trig = req.wr && req.addr == trigger_control_addr;
  assign wr_didr = req.wr && req.addr == input_disable_addr;
  assign wr_mask = req.wr && req.addr == irq_mask_addr;
  assign rd_low = req.rd && req.addr == result_low_addr;
  assign rd_high = req.rd && req.addr == result_high_addr;
  assign rd_stat = req.rd && req.addr == irq_status_addr;

  //////////////////////////////////////////////////////////////////////////
  // Control registers.

  logic enable_reg;
  logic auto_reg;
  logic done_reg;
  logic [7:0] trig_reg;
  logic [7:0] didr_reg;
  logic [7:0] mask_reg;
  logic [7:0] stat_reg;
  logic [7:0] pins_sync;
  logic trigger_edge;
  logic conv_finish;
  logic lock_reg;
  logic [9:0] result_reg;

  // Enable and auto-trigger bits of control A.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_reg <= 1'b0;
      auto_reg <= 1'b0;
    end else if (wr_ctrl) begin
      enable_reg <= req.wdata[enable_bit];
      auto_reg <= req.wdata[auto_bit];
    end
  end

  // Trigger control; the reserved and unused bits are never stored.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_reg <= reset_byte;
    end else if (wr_trig) begin
      trig_reg <= req.wdata & trigger_write_mask; // [RL10]
    end
  end

  // Input disable and interrupt mask registers.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      didr_reg <= reset_byte;
      mask_reg <= reset_byte;
    end else begin
      if (wr_didr) begin
        didr_reg <= req.wdata;
      end
      if (wr_mask) begin
        mask_reg <= req.wdata & irq_bits_mask;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Trigger and conversion sequencing.

  trigger_select u_trig (
    .clk(clk),
    .rst_n(rst_n),
    .trigger_source_select(trig_reg[2:0]),
    .done_flag(done_reg),
    .event_flags(event_flags),
    .trigger_edge(trigger_edge)
  );

  logic auto_start;
  logic soft_start;
  assign auto_start = enable_reg && auto_reg && trigger_edge; // [RL5] [RL13]
  assign soft_start = wr_ctrl && req.wdata[enable_bit] &&
    req.wdata[start_bit];

  conv_state_e state_reg;
  logic [7:0] count_reg;

  // Conversion timer; losing enable aborts at once.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= conv_idle;
      count_reg <= 8'h00;
    end else if (wr_ctrl ? !req.wdata[enable_bit] : !enable_reg) begin
      state_reg <= conv_idle; // [RL15]
      count_reg <= 8'h00;
    end else begin
      case (state_reg)
        conv_idle: begin
          if (soft_start || auto_start) begin
            state_reg <= conv_busy;
            count_reg <= conv_cycles;
          end
        end
        conv_busy: begin
          count_reg <= count_reg - 8'h01;
          if (count_reg == 8'h01) begin
            state_reg <= conv_done;
          end
        end
        conv_done: begin
          state_reg <= conv_idle;
        end
        default: begin
          state_reg <= conv_idle;
        end
      endcase
    end
  end

  assign conv_finish = state_reg == conv_done;
  assign conversion_start = state_reg == conv_idle &&
    (wr_ctrl ? req.wdata[enable_bit] : enable_reg) &&
    (soft_start || auto_start);
  assign converter_busy = state_reg != conv_idle;

  //////////////////////////////////////////////////////////////////////////
  // Result pair with read lock.

  // Low byte read locks, high byte read unlocks.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_reg <= 1'b0;
    end else if (rd_high) begin
      lock_reg <= 1'b0; // [RL2]
    end else if (rd_low) begin
      lock_reg <= 1'b1; // [RL2]
    end
  end

  // Result capture on completion while unlocked.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result_reg <= reset_result;
    end else if (conv_finish && !lock_reg) begin
      result_reg <= conversion_result; // [RL1]
    end
  end

  // Done flag: set wins over a write-one clear.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done_reg <= 1'b0;
    end else if (conv_finish && !lock_reg) begin
      done_reg <= 1'b1; // [RL14]
    end else if (wr_ctrl && req.wdata[done_bit]) begin
      done_reg <= 1'b0; // [RL14]
    end
  end

  logic [7:0] low_view;
  logic [7:0] high_view;
  // Byte views follow the left-adjust level immediately.
  always_comb begin
    if (left_adjust) begin
      high_view = result_reg[9:2]; // [RL4]
      low_view = {result_reg[1:0], 6'h00}; // [RL4]
    end else begin
      high_view = {6'h00, result_reg[9:8]}; // [RL3]
      low_view = result_reg[7:0]; // [RL3]
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Pin input path.

  sync2 #(.width(8)) u_pins (
    .clk(clk),
    .rst_n(rst_n),
    .d(pin_levels),
    .q(pins_sync)
  );

  assign pin_buffer_enable = ~didr_reg; // [RL11]

  // Port input register masks disabled pins to zero.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port_input <= reset_byte;
    end else begin
      port_input <= pins_sync & ~didr_reg; // [RL12]
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Interrupt status: sticky, cleared by reading, set wins.

  logic [7:0] stat_set;
  assign stat_set = {6'h00, auto_start, conv_finish && !lock_reg};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_reg <= reset_byte;
    end else if (rd_stat) begin
      stat_reg <= stat_set;
    end else begin
      stat_reg <= stat_reg | stat_set;
    end
  end

  assign irq = |(stat_reg & mask_reg);

  //////////////////////////////////////////////////////////////////////////
  // Read data, valid the cycle after the strobe.

  logic [7:0] ctrl_view;
  assign ctrl_view = {enable_reg, converter_busy, auto_reg, done_reg, 4'h0};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= reset_byte;
    end else if (req.rd) begin
      case (req.addr)
        result_low_addr: rdata <= low_view;
        result_high_addr: rdata <= high_view;
        control_a_addr: rdata <= ctrl_view;
        trigger_control_addr: rdata <= trig_reg;
        irq_status_addr: rdata <= stat_reg;
        irq_mask_addr: rdata <= mask_reg;
        input_disable_addr: rdata <= didr_reg;
        default: rdata <= reset_byte;
      endcase
    end else begin
      rdata <= reset_byte;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence s_locked_finish;
    lock_reg && conv_finish;
  endsequence

  property p_lock_hold;
    @(posedge clk) disable iff (!rst_n)
    s_locked_finish |=> $stable(result_reg) && !$rose(done_reg);
  endproperty
  a_lock_hold: assert property (p_lock_hold) // [RL2]
    else $error("result changed while locked");

  property p_update;
    @(posedge clk) disable iff (!rst_n)
    (conv_finish && !lock_reg) |=> result_reg == $past(conversion_result);
  endproperty
  a_update: assert property (p_update) // [RL1]
    else $error("result not captured");

  property p_right;
    @(posedge clk) disable iff (!rst_n)
    (rd_high && !left_adjust) |=> rdata == {6'h00, $past(result_reg[9:8])};
  endproperty
  a_right: assert property (p_right) // [RL3]
    else $error("right adjusted high byte wrong");

  property p_left;
    @(posedge clk) disable iff (!rst_n)
    (rd_low && left_adjust) |=> rdata[5:0] == 6'h00;
  endproperty
  a_left: assert property (p_left) // [RL4]
    else $error("left adjusted low byte wrong");

  property p_no_auto;
    @(posedge clk) disable iff (!rst_n)
    (!auto_reg && !wr_ctrl) |-> !conversion_start;
  endproperty
  a_no_auto: assert property (p_no_auto) // [RL5]
    else $error("trigger while auto off");

  property p_free_switch;
    @(posedge clk) disable iff (!rst_n)
    (trig_reg[2:0] == src_free_running && $past(trig_reg[2:0]) != 3'h0)
      |-> !trigger_edge;
  endproperty
  a_free_switch: assert property (p_free_switch) // [RL8]
    else $error("free running switch triggered");

  property p_abort;
    @(posedge clk) disable iff (!rst_n)
    (converter_busy && wr_ctrl && !wdata[enable_bit]) |=> !converter_busy;
  endproperty
  a_abort: assert property (p_abort) // [RL15]
    else $error("conversion not aborted");

  property p_pin_zero;
    @(posedge clk) disable iff (!rst_n)
    ##1 (didr_reg[0] && $past(didr_reg[0])) |-> !port_input[0];
  endproperty
  a_pin_zero: assert property (p_pin_zero) // [RL12]
    else $error("disabled pin read nonzero");

  property p_done_set;
    @(posedge clk) disable iff (!rst_n)
    (conv_finish && !lock_reg) |=> done_reg && !converter_busy;
  endproperty
  a_done_set: assert property (p_done_set) // [RL14]
    else $error("done flag not set");

endmodule
`default_nettype wire

// [rtl/adc_regs_pkg.sv]
// Package of constants and types for the converter result and trigger logic.
//
// Contract
// RL1: Each finished conversion loads the result pair unless it is locked.
// RL2: A low byte read blocks result updates until the high byte is read.
// RL3: Left adjust off puts result 9:8 in high bits 1:0 and 7:0 in the low byte.
// RL4: Left adjust on puts result 9:2 in the high byte and 1:0 in low bits 7:6.
// RL5: The trigger source selector acts only while auto triggering is enabled.
// RL6: With auto triggering, a selected flag's rising edge starts a conversion.
// RL7: Switching from a clear flag to a set flag counts as a rising edge.
// RL8: Switching to the free-running code never makes a trigger event.
// RL9: Codes 0-7: free, comparator, int0, t0A, t0 ovf, t1B, t1 ovf, capture.
// RL10: Software writes zero to reserved bit 7 of trigger control.
// RL11: A set input-disable bit turns off its pin's digital input buffer.
// RL12: While a pin's input-disable bit is set, its port input bit reads zero.
// RL13: Auto-trigger enable lets the selected trigger's rising edge start.
// RL14: A stored conversion sets the done flag, and writing one clears it.
// RL15: Clearing converter enable turns it off and aborts any conversion.
// RL16: An edge is the selected flag high after being low one clock earlier.
package adc_regs_pkg;

  localparam logic [7:0] result_low_addr = 8'h78;
  localparam logic [7:0] result_high_addr = 8'h79;
  localparam logic [7:0] control_a_addr = 8'h7A;
  localparam logic [7:0] trigger_control_addr = 8'h7B;
  localparam logic [7:0] input_disable_addr = 8'h7E;
  localparam logic [7:0] irq_status_addr = 8'h7C;
  localparam logic [7:0] irq_mask_addr = 8'h7D;

  // Control A field positions.
  localparam int enable_bit = 7;
  localparam int start_bit = 6;
  localparam int auto_bit = 5;
  localparam int done_bit = 4;

  // Trigger control field positions and write mask.
  localparam int comp_mux_bit = 6;
  localparam logic [7:0] trigger_write_mask = 8'h47;
  localparam logic [2:0] src_free_running = 3'h0;

  // Interrupt status bits.
  localparam int irq_done_bit = 0;
  localparam int irq_trig_bit = 1;
  localparam logic [7:0] irq_bits_mask = 8'h03;

  localparam logic [7:0] reset_byte = 8'h00;
  localparam logic [9:0] reset_result = 10'h000;

  // Conversion time in system clocks, a plain stand-in for the analog core.
  localparam int conv_time_ns = 650;
  localparam int clk_period_ns = 50;
  localparam logic [7:0] conv_cycles = 8'((conv_time_ns + clk_period_ns - 1)
                                          / clk_period_ns);

  typedef enum logic [1:0] {
    conv_idle = 2'b00,
    conv_busy = 2'b01,
    conv_done = 2'b11
  } conv_state_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_s;

endpackage

// [rtl/sync2.sv]
// Two-flop synchroniser for a bus of pin levels.
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
  parameter int width = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [width-1:0] d,
  output logic [width-1:0] q
);

  logic [width-1:0] meta_reg;

  // First stage feeds only the second stage.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule
`default_nettype wire

// [rtl/trigger_select.sv]
// Auto-trigger source selection and rising-edge detection.
`timescale 1ns/1ps
`default_nettype none
module trigger_select
  import adc_regs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] trigger_source_select,
  input wire logic done_flag,
  input wire logic [6:0] event_flags,
  output logic trigger_edge
);

  logic sel_flag;
  logic prev_flag_reg;

  // Code 0 watches the done flag, codes 1 to 7 the event flags in order.
  always_comb begin
    if (trigger_source_select == src_free_running) begin // [RL9]
      sel_flag = done_flag;
    end else begin
      sel_flag = event_flags[trigger_source_select - 3'h1];
    end
  end

  // Last cycle's selected flag, for edge detection.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_flag_reg <= 1'b0;
    end else begin
      prev_flag_reg <= sel_flag; // [RL16]
    end
  end

  // Switching to free running from another source never gives an edge.
  logic prev_src_free_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_src_free_reg <= 1'b1;
    end else begin
      prev_src_free_reg <= (trigger_source_select == src_free_running);
    end
  end

  assign trigger_edge = sel_flag && !prev_flag_reg && // [RL6] [RL7]
    !(trigger_source_select == src_free_running && // [RL8]
      !prev_src_free_reg);

endmodule
`default_nettype wire

// [verification/adc_result_and_trigger_regs_test.sv]
// Self-checking testbench for the converter result and trigger registers.
`timescale 1ns/1ps
`default_nettype none
module adc_result_and_trigger_regs_test
  import adc_regs_pkg::*;
;
  logic clk, rst_n, wr, rd, left_adjust, conversion_start;
  logic converter_busy, irq, last_start, seen;
  logic [7:0] addr, wdata, rdata, pin_levels, port_input, pin_buffer_enable;
  logic [7:0] v, d, p;
  logic [9:0] conversion_result, r1, r2;
  logic [6:0] event_flags;
  int bad_count, samples_checked;

  ////////////////////////////////////////////////////////////////////////////
  // Design under test with every input driven by the bench.
  adc_result_and_trigger_regs i_dut (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .left_adjust(left_adjust),
    .conversion_result(conversion_result), .event_flags(event_flags),
    .pin_levels(pin_levels), .port_input(port_input),
    .pin_buffer_enable(pin_buffer_enable),
    .conversion_start(conversion_start), .converter_busy(converter_busy),
    .irq(irq)
  );

  // Clock at 20 MHz.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Expected byte layouts for both adjust settings.
  function automatic logic [7:0] hi_byte(logic [9:0] r, logic la);
    return la ? r[9:2] : {6'h00, r[9:8]};
  endfunction

  function automatic logic [7:0] lo_byte(logic [9:0] r, logic la);
    return la ? {r[1:0], 6'h00} : r[7:0];
  endfunction

  // Prints the counts and the verdict, then ends the run.
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Compares a seen value with the expected one.
  task automatic check(string n, logic [7:0] e, logic [7:0] s);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask

  // One-cycle write; the start pulse is sampled inside the write cycle.
  task automatic wr_reg(logic [7:0] a, logic [7:0] dv);
    @(posedge clk);
    addr <= a;
    wdata <= dv;
    wr <= 1'b1;
    @(negedge clk);
    last_start = conversion_start;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // One-cycle read; data are taken in the cycle after the strobe.
  task automatic rd_reg(logic [7:0] a, output logic [7:0] q);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    q = rdata;
  endtask

  // Waits a bounded time for the converter to go idle.
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (converter_busy !== 1'b0 && n < 40);
    if (n >= 40) begin
      bad_count++;
      $display("FAIL converter_busy expected 0 seen 1");
      conclude();
    end
  endtask

  // Looks for a start pulse over the next three cycles.
  task automatic watch(output logic s);
    s = 1'b0;
    repeat (3) begin
      @(negedge clk);
      if (conversion_start === 1'b1) s = 1'b1;
    end
  endtask

  // Manual conversion with a held result value.
  task automatic convert(logic [9:0] r);
    @(posedge clk) conversion_result <= r;
    wr_reg(control_a_addr, 8'hC0);
    check("conversion_start", 8'h01, {7'h00, last_start});
    wait_idle();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    left_adjust = 1'b0;
    conversion_result = 10'h000;
    event_flags = 7'h00;
    pin_levels = 8'h00;
    bad_count = 0;
    samples_checked = 0;
    v = 8'($urandom(32'hce450921));
    repeat (20) @(posedge clk);
    check("buffer_in_reset", 8'hFF, pin_buffer_enable);
    rst_n <= 1'b1;
    // Reset values, with an unmapped address last.
    for (int i = 0; i < 5; i++) begin
      rd_reg(i == 0 ? result_low_addr : i == 1 ? result_high_addr :
             i == 2 ? trigger_control_addr :
             i == 3 ? input_disable_addr : 8'h70, v);
      check("reset_read", 8'h00, v);
    end
    // Only the selector and comparator bits are stored; bit 7 written zero.
    wr_reg(trigger_control_addr, 8'h7F);
    rd_reg(trigger_control_addr, v);
    check("trigger_control", 8'h47, v);
    wr_reg(trigger_control_addr, 8'h00);
    // Input disable against random pin levels, all-ones corner first.
    for (int i = 0; i < 4; i++) begin
      d = i == 0 ? 8'hFF : 8'($urandom);
      p = i == 0 ? 8'hFF : 8'($urandom);
      wr_reg(input_disable_addr, d);
      @(posedge clk) pin_levels <= p;
      repeat (4) @(negedge clk);
      check("port_input", p & ~d, port_input);
      check("pin_buffer_enable", ~d, pin_buffer_enable);
      rd_reg(input_disable_addr, v);
      check("input_disable", d, v);
    end
    // Result layouts and the done flag.
    for (int i = 0; i < 3; i++) begin
      r1 = i == 0 ? 10'h3FF : i == 1 ? 10'h201 : 10'($urandom);
      convert(r1);
      rd_reg(control_a_addr, v);
      check("done_set", 8'h01, {7'h00, v[done_bit]});
      wr_reg(control_a_addr, 8'h90);
      rd_reg(control_a_addr, v);
      check("done_clear", 8'h00, {7'h00, v[done_bit]});
      left_adjust <= 1'b0;
      rd_reg(result_low_addr, v);
      check("low_right", lo_byte(r1, 1'b0), v);
      rd_reg(result_high_addr, v);
      check("high_right", hi_byte(r1, 1'b0), v);
      left_adjust <= 1'b1;
      rd_reg(result_low_addr, v);
      check("low_left", lo_byte(r1, 1'b1), v);
      rd_reg(result_high_addr, v);
      check("high_left", hi_byte(r1, 1'b1), v);
    end
    // Lock: a completion after the low read is dropped.
    left_adjust <= 1'b0;
    r2 = ~r1;
    rd_reg(result_low_addr, v);
    convert(r2);
    rd_reg(control_a_addr, v);
    check("done_locked", 8'h00, {7'h00, v[done_bit]});
    rd_reg(result_high_addr, v);
    check("high_locked", hi_byte(r1, 1'b0), v);
    convert(r2);
    rd_reg(result_low_addr, v);
    check("low_after", lo_byte(r2, 1'b0), v);
    rd_reg(result_high_addr, v);
    check("high_after", hi_byte(r2, 1'b0), v);
    // Interrupt raised, cleared by reading status, then masked.
    rd_reg(irq_status_addr, v);
    wr_reg(irq_mask_addr, 8'h01);
    wr_reg(control_a_addr, 8'h90);
    convert(r1);
    check("irq_raised", 8'h01, {7'h00, irq});
    rd_reg(irq_status_addr, v);
    check("irq_status", 8'h01, v);
    check("irq_cleared", 8'h00, {7'h00, irq});
    wr_reg(irq_mask_addr, 8'h00);
    convert(r1);
    check("irq_masked", 8'h00, {7'h00, irq});
    // Abort by clearing the enable in mid-conversion.
    wr_reg(control_a_addr, 8'h90);
    wr_reg(control_a_addr, 8'hC0);
    wr_reg(control_a_addr, 8'h00);
    repeat (2) @(negedge clk);
    check("busy_abort", 8'h00, {7'h00, converter_busy});
    repeat (20) @(posedge clk);
    rd_reg(control_a_addr, v);
    check("done_abort", 8'h00, {7'h00, v[done_bit]});
    // Trigger codes 1 to 7; a wrong flag must not start a conversion.
    wr_reg(control_a_addr, 8'hB0);
    for (int k = 1; k < 8; k++) begin
      wr_reg(trigger_control_addr, 8'(k));
      @(posedge clk) event_flags <= 7'h01 << (k % 7);
      watch(seen);
      check("wrong_flag", 8'h00, {7'h00, seen});
      @(posedge clk) event_flags <= 7'h01 << (k - 1);
      watch(seen);
      check("auto_start", 8'h01, {7'h00, seen});
      wait_idle();
      @(posedge clk) event_flags <= 7'h00;
    end
    // Auto starts and their completions both left sticky status bits.
    rd_reg(irq_status_addr, v);
    check("irq_auto_status", 8'h03, v);
    // Auto triggering off: the selector is ignored.
    wr_reg(control_a_addr, 8'h80);
    wr_reg(trigger_control_addr, 8'h01);
    @(posedge clk) event_flags <= 7'h01;
    watch(seen);
    check("auto_off", 8'h00, {7'h00, seen});
    // Switching from a clear flag to a set flag starts a conversion.
    wr_reg(control_a_addr, 8'hB0);
    @(posedge clk) event_flags <= 7'h02;
    repeat (2) @(posedge clk);
    wr_reg(trigger_control_addr, 8'h02);
    watch(seen);
    check("switch_edge", 8'h01, {7'h00, seen});
    wait_idle();
    // Switching to free running with the done flag set never triggers.
    @(posedge clk) event_flags <= 7'h00;
    wr_reg(trigger_control_addr, 8'h01);
    rd_reg(control_a_addr, v);
    check("done_before", 8'h01, {7'h00, v[done_bit]});
    wr_reg(trigger_control_addr, 8'h00);
    watch(seen);
    check("free_switch", 8'h00, {7'h00, seen});
    wr_reg(control_a_addr, 8'h00);
    conclude();
  end
endmodule
`default_nettype wire
